/* rtl/rms_sequencer.sv */
// Purpose: Autonomous mode sequencer with APB register access
// Assumes: Radio events are one-cycle pulses on clk_sys
// Notes: Chip mode output tells the radio which mode to run
// Notes on behaviour
// R1 - Idle on first timer event: select 0 to transmit, 1 to receive
// R2 - Transmit on frame sent: select 0 to low power, 1 to receive
// R3 - Receive exits 001/010/011 on frame complete or check pass
// R4 - Select 011, frame complete with check enabled and no check pass goes to timeout handling
// R5 - Select 100/101/110 halt on level, pattern or lead-in event
// R6 - Second timer event in receive always goes to low power selection
// R7 - Timeout select: 00 relaunch receive, 01 transmit, 10 low power, 11 halt
// R8 - Any of three wait expiries counts as receive wait expired
// R9 - Frame held: 000 halt, 001 transmit on queue drained, 010 low power
// R10 - Frame held: 011 receive via synth only if frequency changed, else directly, 100 receive directly
// R11 - Tick field: disabled, 64 us, 4.1 ms, 262 ms for both timers
// R12 - First timer fires one interval after second timer event or launch
// R13 - Second timer fires one interval after each first timer event
// R14 - Timer chain runs regardless of sequencer state
// R15 - Host enables both timers for periodic cycling
// R16 - Halt bit forces the halted state at any time
// R17 - Launch select: 00 low power, 01 receive, 10 transmit, 11 transmit on level
// R18 - Low power choice 0 halts to initial mode, 1 enters idle
// R19 - Idle chip mode 0 standby, 1 sleep
// R20 - Host never sets launch and halt in one write
// R21 - Timers load multiplier, count down, pulse one clock, hand off
module rms_sequencer
  import rms_pkg::*;
#(
  parameter int mult_width = 8,
  parameter int fast_cycles = rms_tick_fast_cycles,
  parameter int mid_cycles = rms_tick_mid_cycles,
  parameter int slow_cycles = rms_tick_slow_cycles
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Radio events
  input wire logic frame_sent_event,
  input wire logic rx_frame_complete_event,
  input wire logic check_pass_event,
  input wire logic check_enabled,
  input wire logic signal_level_event,
  input wire logic pattern_match_event,
  input wire logic lead_in_found_event,
  input wire logic level_wait_expired,
  input wire logic lead_in_wait_expired,
  input wire logic pattern_wait_expired,
  input wire logic queue_drained_event,
  input wire logic queue_level_event,
  input wire logic freq_changed,
  input wire logic initial_sleep,
  // Radio control
  output rms_chip_mode_type chip_mode,
  output logic synth_only_mode,
  output logic rx_relaunch,
  output logic seq_active,
  output logic first_timer_event,
  output logic second_timer_event
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] sel_reg;
  logic [31:0] timer_reg;
  logic seq_launch_cmd;
  logic halt_cmd;
  logic saved_sleep;
  rms_state_type state;
  rms_state_type next_state;
  logic t1_done;
  logic t2_done;
  logic t1_run;
  logic t2_run;

  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic mapped = paddr == rms_ctrl_addr || paddr == rms_sel_addr ||
                      paddr == rms_timer_addr || paddr == rms_status_addr;

  wire logic idle_chip_mode = ctrl_reg[rms_idle_mode_bit];
  wire logic low_power_choice = ctrl_reg[rms_low_power_bit];
  wire logic idle_exit_select = ctrl_reg[rms_idle_exit_bit];
  wire logic tx_exit_select = ctrl_reg[rms_tx_exit_bit];
  wire logic [1:0] launch_exit_select = ctrl_reg[rms_launch_sel_lsb +: 2];
  wire logic [2:0] rx_exit_select = sel_reg[rms_rx_exit_lsb +: 3];
  wire logic [1:0] timeout_exit_select = sel_reg[rms_timeout_exit_lsb +: 2];
  wire logic [2:0] rx_done_exit_select = sel_reg[rms_rx_done_exit_lsb +: 3];
  wire logic [1:0] first_timer_tick = timer_reg[rms_t1_tick_lsb +: 2];
  wire logic [1:0] second_timer_tick = timer_reg[rms_t2_tick_lsb +: 2];
  wire logic [mult_width-1:0] first_timer_multiplier = timer_reg[rms_t1_mult_lsb +: mult_width];
  wire logic [mult_width-1:0] second_timer_multiplier = timer_reg[rms_t2_mult_lsb +: mult_width];
  wire logic rx_wait_expired = level_wait_expired || lead_in_wait_expired || pattern_wait_expired; // R8

  // Launch and halt bits are self-clearing strobes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_reg <= rms_ctrl_reset;
      sel_reg <= rms_sel_reset;
      timer_reg <= rms_timer_reset;
      seq_launch_cmd <= 1'b0;
      halt_cmd <= 1'b0;
    end else begin
      seq_launch_cmd <= 1'b0;
      halt_cmd <= 1'b0;
      if (wr && paddr == rms_ctrl_addr) begin
        ctrl_reg <= {24'h0, pwdata[7:2], 2'b00};
        seq_launch_cmd <= pwdata[rms_launch_bit];
        halt_cmd <= pwdata[rms_halt_bit]; // R16
      end
      if (wr && paddr == rms_sel_addr) begin
        sel_reg <= {21'h0, pwdata[10:8], 2'b00, pwdata[5:4], 1'b0, pwdata[2:0]};
      end
      if (wr && paddr == rms_timer_addr) begin
        timer_reg <= {8'h0, pwdata[23:16], pwdata[15:8], 4'h0, pwdata[3:0]};
      end
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Zero wait states: pready rises one cycle after the setup phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          rms_ctrl_addr: prdata <= ctrl_reg;
          rms_sel_addr: prdata <= sel_reg;
          rms_timer_addr: prdata <= timer_reg;
          rms_status_addr: prdata <= {24'h0, 4'(state), seq_active, t2_run, t1_run, 1'b0};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // Timer chain
  // ****************************************
  rms_interval_timer #(
    .mult_width(mult_width),
    .fast_cycles(fast_cycles),
    .mid_cycles(mid_cycles),
    .slow_cycles(slow_cycles)
  ) u_first_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(seq_launch_cmd || t2_done), // R12
    .abort(halt_cmd),
    .tick_sel(first_timer_tick),
    .multiplier(first_timer_multiplier),
    .running(t1_run),
    .done(t1_done)
  );

  rms_interval_timer #(
    .mult_width(mult_width),
    .fast_cycles(fast_cycles),
    .mid_cycles(mid_cycles),
    .slow_cycles(slow_cycles)
  ) u_second_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(t1_done), // R13
    .abort(halt_cmd),
    .tick_sel(second_timer_tick),
    .multiplier(second_timer_multiplier),
    .running(t2_run),
    .done(t2_done)
  );

  // Timer events are not gated by state; they reach the pins registered, one clock after done
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      first_timer_event <= 1'b0;
      second_timer_event <= 1'b0;
    end else begin
      first_timer_event <= t1_done; // R14
      second_timer_event <= t2_done; // R14
    end
  end

  // ****************************************
  // State machine
  // ****************************************
  function automatic rms_state_type timeout_dest(input logic [1:0] sel);
    case (sel)
      rms_to_relaunch: timeout_dest = rms_receive;
      rms_to_tx: timeout_dest = rms_transmit;
      rms_to_low: timeout_dest = rms_low_power;
      default: timeout_dest = rms_halted;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      rms_halted: begin
        if (seq_launch_cmd) begin
          case (launch_exit_select) // R17
            rms_launch_low: next_state = rms_low_power;
            rms_launch_rx: next_state = rms_receive;
            rms_launch_tx: next_state = rms_transmit;
            default: next_state = rms_launch_wait;
          endcase
        end
      end
      rms_launch_wait: if (queue_level_event) next_state = rms_transmit; // R17
      rms_idle: if (t1_done) next_state = idle_exit_select ? rms_receive : rms_transmit; // R1
      rms_transmit: if (frame_sent_event) next_state = tx_exit_select ? rms_receive : rms_low_power; // R2
      rms_receive: begin
        if (t2_done) begin
          next_state = rms_low_power; // R6
        end else if (rx_wait_expired) begin
          next_state = rms_rx_timeout; // R7
        end else begin
          case (rx_exit_select)
            rms_rx_on_done: if (rx_frame_complete_event) next_state = rms_frame_held; // R3
            rms_rx_done_low: if (rx_frame_complete_event) next_state = rms_low_power; // R3
            rms_rx_on_check: begin
              if (check_pass_event) begin
                next_state = rms_frame_held; // R3
              end else if (rx_frame_complete_event && check_enabled) begin
                next_state = rms_rx_timeout; // R4
              end
            end
            rms_rx_on_level: if (signal_level_event) next_state = rms_halted; // R5
            rms_rx_on_pattern: if (pattern_match_event) next_state = rms_halted; // R5
            rms_rx_on_lead_in: if (lead_in_found_event) next_state = rms_halted; // R5
            default: next_state = rms_receive;
          endcase
        end
      end
      rms_rx_timeout: next_state = timeout_dest(timeout_exit_select); // R7
      rms_frame_held: begin
        case (rx_done_exit_select)
          rms_held_halt: next_state = rms_halted; // R9
          rms_held_tx: if (queue_drained_event) next_state = rms_transmit; // R9
          rms_held_low: next_state = rms_low_power; // R9
          rms_held_rx_synth: next_state = freq_changed ? rms_synth_only : rms_receive; // R10
          rms_held_rx: next_state = rms_receive; // R10
          default: next_state = rms_frame_held;
        endcase
      end
      rms_synth_only: next_state = rms_receive; // R10
      rms_low_power: next_state = low_power_choice ? rms_idle : rms_halted; // R18
      default: next_state = rms_halted;
    endcase
    if (halt_cmd) next_state = rms_halted; // R16
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= rms_halted;
    end else begin
      state <= next_state;
    end
  end

  // Initial low-power mode is captured when the sequencer is launched
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      saved_sleep <= 1'b0;
    end else if (seq_launch_cmd && state == rms_halted) begin
      saved_sleep <= initial_sleep;
    end
  end

  // ****************************************
  // Radio control outputs
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chip_mode <= rms_chip_standby;
      synth_only_mode <= 1'b0;
      rx_relaunch <= 1'b0;
      seq_active <= 1'b0;
    end else begin
      seq_active <= next_state != rms_halted;
      synth_only_mode <= next_state == rms_synth_only; // R10
      rx_relaunch <= state == rms_rx_timeout && next_state == rms_receive; // R7
      case (next_state)
        rms_idle: chip_mode <= idle_chip_mode ? rms_chip_sleep : rms_chip_standby; // R19
        rms_transmit: chip_mode <= rms_chip_tx;
        rms_receive, rms_frame_held, rms_rx_timeout: chip_mode <= rms_chip_rx;
        rms_halted: chip_mode <= saved_sleep ? rms_chip_sleep : rms_chip_standby; // R18
        default: chip_mode <= chip_mode;
      endcase
    end
  end

endmodule // rms_sequencer

/* rtl/rms_pkg.sv */
// Purpose: Shared constants for the radio mode sequencer
// Assumes: 250 MHz system clock
// Notes: Register offsets are byte addresses on APB
package rms_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] rms_ctrl_addr = 8'h00;
  localparam logic [7:0] rms_sel_addr = 8'h04;
  localparam logic [7:0] rms_timer_addr = 8'h08;
  localparam logic [7:0] rms_status_addr = 8'h0c;

  // Control register fields
  localparam int rms_launch_bit = 0;
  localparam int rms_halt_bit = 1;
  localparam int rms_idle_mode_bit = 2;
  localparam int rms_low_power_bit = 3;
  localparam int rms_idle_exit_bit = 4;
  localparam int rms_tx_exit_bit = 5;
  localparam int rms_launch_sel_lsb = 6;

  // Selection register fields
  localparam int rms_rx_exit_lsb = 0;
  localparam int rms_timeout_exit_lsb = 4;
  localparam int rms_rx_done_exit_lsb = 8;

  // Timer register fields
  localparam int rms_t1_tick_lsb = 0;
  localparam int rms_t2_tick_lsb = 2;
  localparam int rms_t1_mult_lsb = 8;
  localparam int rms_t2_mult_lsb = 16;

  localparam logic [31:0] rms_ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] rms_sel_reset = 32'h0000_0000;
  localparam logic [31:0] rms_timer_reset = 32'h0000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int rms_clk_mhz = 250;
  localparam int rms_tick_fast_ns = 64000;
  localparam int rms_tick_mid_ns = 4100000;
  localparam int rms_tick_slow_ns = 262000000;
  localparam int rms_clk_period_ns = 1000 / rms_clk_mhz;
  localparam int rms_tick_fast_cycles = rms_tick_fast_ns / rms_clk_period_ns;
  localparam int rms_tick_mid_cycles = rms_tick_mid_ns / rms_clk_period_ns;
  localparam int rms_tick_slow_cycles = rms_tick_slow_ns / rms_clk_period_ns;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum {
    rms_halted, rms_idle, rms_transmit, rms_receive, rms_frame_held,
    rms_low_power, rms_rx_timeout, rms_launch_wait, rms_synth_only
  } rms_state_type;

  typedef enum logic [1:0] {
    rms_chip_standby, rms_chip_sleep, rms_chip_tx, rms_chip_rx
  } rms_chip_mode_type;

  localparam logic [2:0] rms_rx_on_done = 3'h1;
  localparam logic [2:0] rms_rx_done_low = 3'h2;
  localparam logic [2:0] rms_rx_on_check = 3'h3;
  localparam logic [2:0] rms_rx_on_level = 3'h4;
  localparam logic [2:0] rms_rx_on_pattern = 3'h5;
  localparam logic [2:0] rms_rx_on_lead_in = 3'h6;

  localparam logic [1:0] rms_to_relaunch = 2'h0;
  localparam logic [1:0] rms_to_tx = 2'h1;
  localparam logic [1:0] rms_to_low = 2'h2;

  localparam logic [2:0] rms_held_halt = 3'h0;
  localparam logic [2:0] rms_held_tx = 3'h1;
  localparam logic [2:0] rms_held_low = 3'h2;
  localparam logic [2:0] rms_held_rx_synth = 3'h3;
  localparam logic [2:0] rms_held_rx = 3'h4;

  localparam logic [1:0] rms_launch_low = 2'h0;
  localparam logic [1:0] rms_launch_rx = 2'h1;
  localparam logic [1:0] rms_launch_tx = 2'h2;

endpackage

/* rtl/rms_interval_timer.sv */
// Purpose: One interval timer of the sequencer chain
// Assumes: Tick base of 64 us, 4.1 ms or 262 ms from the tick field
// Notes: Counts multiplier tick periods, then pulses done for one clock
module rms_interval_timer
  import rms_pkg::*;
#(
  parameter int mult_width = 8,
  parameter int fast_cycles = rms_tick_fast_cycles,
  parameter int mid_cycles = rms_tick_mid_cycles,
  parameter int slow_cycles = rms_tick_slow_cycles
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] tick_sel,
  input wire logic [mult_width-1:0] multiplier,
  // Result
  output logic running,
  output logic done
);

  logic [27:0] prescale;
  logic [mult_width-1:0] remain;

  function automatic logic [27:0] tick_cycles(input logic [1:0] sel);
    case (sel)
      2'h1: tick_cycles = 28'(fast_cycles);
      2'h2: tick_cycles = 28'(mid_cycles);
      2'h3: tick_cycles = 28'(slow_cycles);
      default: tick_cycles = 28'h0;
    endcase
  endfunction

  // A disabled tick field or zero multiplier never starts, breaking the chain
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    if (reset || abort) begin
      running <= 1'b0;
      prescale <= 28'h0;
      remain <= '0;
    end else if (start) begin
      running <= (tick_sel != 2'h0) && (multiplier != '0); // R11 R21
      // The start edge is one cycle late behind the previous done, so count it as elapsed.
      // Tick counts below two cycles are not supported.
      prescale <= tick_cycles(tick_sel) - 28'h2; // R12 R13
      remain <= multiplier;
    end else if (running) begin
      if (prescale == 28'h0) begin
        prescale <= tick_cycles(tick_sel) - 28'h1; // R11
        remain <= remain - 1'b1;
        if (remain == mult_width'(1)) begin
          running <= 1'b0;
          done <= 1'b1; // R21
        end
      end else begin
        prescale <= prescale - 28'h1;
      end
    end
  end

endmodule // rms_interval_timer

/* bench/rms_seq_assertions.sv */
// Purpose: Port-level checks on the radio mode sequencer
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to the design from the testbench top file
module rms_seq_assertions
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Radio side
  input wire logic frame_sent_event,
  input wire rms_chip_mode_type chip_mode,
  input wire logic synth_only_mode,
  input wire logic rx_relaunch,
  input wire logic seq_active,
  input wire logic first_timer_event,
  input wire logic second_timer_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ****************************************
  // Properties
  // ****************************************
  sequence s_halt_wr;
    psel && penable && pready && pwrite && paddr == rms_ctrl_addr && pwdata[rms_halt_bit];
  endsequence
  sequence s_timers_quiet;
    (!first_timer_event && !second_timer_event) [*4];
  endsequence

  property p_halt_off;
    s_halt_wr |-> ##[1:3] !seq_active;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt write left sequencer active");

  // Halt also clears both timers, so the chain must fall silent
  property p_halt_quiet;
    s_halt_wr |-> ##3 s_timers_quiet;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("timer event after halt");

  property p_t1_pulse;
    first_timer_event |=> !first_timer_event;
  endproperty
  a_t1_pulse: assert property (p_t1_pulse) else $error("first timer event not one cycle");

  property p_t2_pulse;
    second_timer_event |=> !second_timer_event;
  endproperty
  a_t2_pulse: assert property (p_t2_pulse) else $error("second timer event not one cycle");

  property p_alternate;
    !(first_timer_event && second_timer_event);
  endproperty
  a_alternate: assert property (p_alternate) else $error("both timer events together");

  property p_synth;
    $rose(synth_only_mode) |-> ##[1:3] chip_mode == rms_chip_rx;
  endproperty
  a_synth: assert property (p_synth) else $error("synth step did not return to receive");

  property p_relaunch;
    rx_relaunch |-> ##[0:2] (chip_mode == rms_chip_rx && seq_active);
  endproperty
  a_relaunch: assert property (p_relaunch) else $error("relaunch did not stay in receive");

  property p_off_low;
    !seq_active |-> chip_mode inside {rms_chip_standby, rms_chip_sleep};
  endproperty
  a_off_low: assert property (p_off_low) else $error("halted with radio on");

  property p_tx_exit;
    (frame_sent_event && chip_mode == rms_chip_tx) |-> ##[1:3] chip_mode != rms_chip_tx;
  endproperty
  a_tx_exit: assert property (p_tx_exit) else $error("transmit kept after frame sent");

  property p_t2_rx;
    (second_timer_event && $past(chip_mode) == rms_chip_rx) |-> ##[0:2] chip_mode != rms_chip_rx;
  endproperty
  a_t2_rx: assert property (p_t2_rx) else $error("receive kept after second timer");
endmodule // rms_seq_assertions

/* bench/rms_host_model.sv */
// Purpose: Host that issues one APB transfer per bench request
// Assumes: Zero or more wait states from the slave
// Notes: Address and data are scrambled once released
module rms_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bench request
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic busy,
  output logic [31:0] rd,
  output logic err,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      busy <= 1'b0;
      rd <= 32'h0;
      err <= 1'b0;
    end else if (!busy && go) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      busy <= 1'b1;
    end else if (psel && !penable) begin
      penable <= 1'b1;
    end else if (psel && penable && pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not look like a still-valid request
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      rd <= prdata;
      err <= pslverr;
      busy <= 1'b0;
    end
  end
endmodule // rms_host_model

/* bench/tb_rms_sequencer.sv */
// Purpose: Self-checking bench for the radio mode sequencer
// Assumes: Short tick parameters 4, 8 and 16 cycles
// Notes: Sequencer state is read back through the status register
module tb_rms_sequencer
  import rms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] c; logic [11:0] s; int e0; int e1; logic [3:0] st;} rms_row_type;
  logic clk_sys, reset, go, wr, busy, err, check_enabled, freq_changed, initial_sleep;
  logic psel, penable, pwrite, pready, pslverr, synth_only_mode, rx_relaunch, seq_active;
  logic first_timer_event, second_timer_event;
  logic [7:0] addr, paddr;
  logic [31:0] wdata, rd, pwdata, prdata;
  logic [10:0] ev;
  rms_chip_mode_type chip_mode;
  int num_errors, n_checks, k, t;
  int n_synth = 0;
  int n_relaunch = 0;
  rms_row_type rows[19] = '{
    '{8'h80, 12'h000, 0, -1, 0}, '{8'ha0, 12'h000, 0, -1, 3},
    '{8'h40, 12'h101, 1, 9, 2}, '{8'h48, 12'h102, 1, -1, 1}, '{8'h40, 12'h103, 2, -1, 4},
    '{8'h40, 12'h104, 3, -1, 0}, '{8'h40, 12'h105, 4, -1, 0}, '{8'h40, 12'h106, 5, -1, 0},
    '{8'h40, 12'h111, 6, -1, 2}, '{8'h40, 12'h131, 7, -1, 0}, '{8'h48, 12'h121, 8, -1, 1},
    '{8'h40, 12'h101, 6, -1, 3}, '{8'h40, 12'h113, 1, -1, 2},
    '{8'h08, 12'h000, -1, -1, 1}, '{8'hc0, 12'h000, 10, -1, 2},
    '{8'h40, 12'h001, 1, -1, 0}, '{8'h48, 12'h201, 1, -1, 1},
    '{8'h40, 12'h401, 1, -1, 3}, '{8'h40, 12'h301, 1, -1, 3}};

  rms_host_model host (.clk_sys(clk_sys), .reset(reset), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .busy(busy), .rd(rd), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rms_sequencer #(.mult_width(8), .fast_cycles(4), .mid_cycles(8), .slow_cycles(16)) dut (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_sent_event(ev[0]),
    .rx_frame_complete_event(ev[1]), .check_pass_event(ev[2]), .check_enabled(check_enabled),
    .signal_level_event(ev[3]), .pattern_match_event(ev[4]), .lead_in_found_event(ev[5]),
    .level_wait_expired(ev[6]), .lead_in_wait_expired(ev[7]), .pattern_wait_expired(ev[8]),
    .queue_drained_event(ev[9]), .queue_level_event(ev[10]), .freq_changed(freq_changed),
    .initial_sleep(initial_sleep), .chip_mode(chip_mode), .synth_only_mode(synth_only_mode),
    .rx_relaunch(rx_relaunch), .seq_active(seq_active), .first_timer_event(first_timer_event),
    .second_timer_event(second_timer_event));

  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys); go <= 1'b1; wr <= w; addr <= a; wdata <= d;
    @(posedge clk_sys); go <= 1'b0;
    #1;
    n = 0;
    while (busy && n < 40) begin @(posedge clk_sys); #1; n++; end
    if (busy) begin num_errors++; test_done; end
  endtask
  task fire(input int i);
    if (i >= 0) begin
      @(posedge clk_sys); ev[i] <= 1'b1;
      @(posedge clk_sys); ev <= '0;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Pulse outputs are counted here and compared once the rows are done
  always @(posedge clk_sys) begin
    if (!reset) begin
      n_synth <= n_synth + 32'(synth_only_mode);
      n_relaunch <= n_relaunch + 32'(rx_relaunch);
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reset, go, wr, addr, wdata, ev} = {1'b1, 53'h0};
    {check_enabled, freq_changed, initial_sleep} = 3'b110;
    num_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    check(32'(seq_active), 0);
    for (int a = 0; a < 3; a++) begin
      bus(1'b0, 8'(a * 4), 0);
      check(rd, 32'h0);
      check(32'(err), 32'h0);
    end
    bus(1'b1, 8'h10, 32'hffff_ffff);
    bus(1'b0, 8'h10, 0);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    foreach (rows[i]) begin
      bus(1'b1, rms_ctrl_addr, 32'h2);
      bus(1'b1, rms_sel_addr, 32'(rows[i].s));
      bus(1'b1, rms_ctrl_addr, 32'(rows[i].c) | 32'h1);
      fire(rows[i].e0);
      fire(rows[i].e1);
      bus(1'b0, rms_status_addr, 0);
      check(32'(rd[7:4]), 32'(rows[i].st));
    end
    check(n_synth, 1);
    check(n_relaunch, 1);
    // Periodic cycle: idle to receive on first timer, back on second
    bus(1'b1, rms_ctrl_addr, 32'h2);
    initial_sleep <= 1'b1;
    bus(1'b1, rms_timer_addr, 32'h0003_0509);
    bus(1'b1, rms_ctrl_addr, 32'h1d);
    repeat (2) @(posedge clk_sys);
    #1;
    check(32'(chip_mode), 32'(rms_chip_sleep));
    for (int r = 0; r < 2; r++) begin
      k = 0;
      while (!first_timer_event && k < 300) begin @(posedge clk_sys); #1; k++; end
      if (r == 1) check(k, 20);
      t = 0;
      while (!second_timer_event && t < 300) begin
        @(posedge clk_sys); #1; t++;
        if (t == 6) check(32'(chip_mode), 32'(rms_chip_rx));
      end
      check(t, 24);
      if (k == 300 || t == 300) begin
        num_errors++;
        test_done;
      end
    end
    repeat (3) @(posedge clk_sys);
    #1;
    check(32'(chip_mode), 32'(rms_chip_sleep));
    bus(1'b1, rms_ctrl_addr, 32'h2);
    @(posedge clk_sys);
    #1;
    check({seq_active, chip_mode}, {1'b0, rms_chip_sleep});
    k = 0;
    repeat (60) begin @(posedge clk_sys); #1; k += first_timer_event + second_timer_event; end
    check(k, 0);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus(1'b0, rms_timer_addr, 0);
    check(rd, rms_timer_reset);
    test_done;
  end
endmodule // tb_rms_sequencer

bind rms_sequencer rms_seq_assertions chk (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .frame_sent_event(frame_sent_event),
  .chip_mode(chip_mode), .synth_only_mode(synth_only_mode), .rx_relaunch(rx_relaunch),
  .seq_active(seq_active), .first_timer_event(first_timer_event), .second_timer_event(second_timer_event));
